// *** pkg/pattern_params.svh ***
/*
 * Constants for the pattern trigger and marker output block: register map,
 * control field positions, reset values and timing counts.
 * Assumes inclusion by bare name in a design file; definitions only.
 */
`ifndef PATTERN_PARAMS_SVH
`define PATTERN_PARAMS_SVH

`define CLK_PERIOD_NS   50
`define SC_PERIOD_MS    26.67
`define SC_CYCLES       (int'(`SC_PERIOD_MS * 1.0e6 / `CLK_PERIOD_NS))
`define TRIG_MIN_NS     100
`define TRIG_MIN_CYC    ((`TRIG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define REG_CTRL        8'h00
`define REG_MKEN        8'h04
`define REG_BITDIV      8'h08
`define REG_PATLEN      8'h0c
`define REG_SYMLEN      8'h10
`define REG_STATUS      8'h14

`define CTL_BB          0
`define CTL_CONT        1
`define CTL_FALL        2
`define CTL_EXT         3
`define CTL_SC          4
`define CTL_ARB         5
`define CTL_TSLOT       6
`define CTL_POL_LO      8
`define CTL_POL_HI      11

`define CTRL_RST        32'h0000_0000
`define MKEN_RST        4'h0
`define BITDIV_RST      8'h04
`define PATLEN_RST      16'h0020
`define SYMLEN_RST      4'h2
`define LFSR_SEED       9'h1ff
`define LFSR_TAP        4
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// *** pkg/pattern_pkg.sv ***
/*
 * Types shared by the pattern trigger and marker output block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pattern_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_WAIT, ST_RUN} run_state_t;
endpackage

// *** verif/pattern_trigger_marker_outputs_bench.sv ***
/* Self-checking bench: register resets, triggers, timing and markers.
   Assumes the design header, package and trigger_source_model. */
`timescale 1ns/1ps
`include "pattern_params.svh"
module pattern_trigger_marker_outputs_bench;
    import pattern_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
    logic        I_CLK, I_RSTN, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
    logic        I_PT_VALID, I_SEG_LOAD, I_SEQ_LOAD, I_ALTERNATE_POWER_SYNC_IN;
    logic        I_PATTERN_TRIGGER_IN, I_PATTERN_TRIGGER_IN_SECONDARY, I_EXT_DATA;
    logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_ARB_TRIG;
    logic        O_EVENT1, O_EVENT2, O_EVENT3, O_EVENT4, O_BIT_CLK, O_SER_DATA;
    logic        O_SYMBOL_SYNC_OUT, lvl, lvl2, aw_done, w_done;
    logic [7:0]  I_AWADDR, I_ARADDR;
    logic [31:0] I_WDATA, O_RDATA, rdat;
    logic [3:0]  I_WSTRB, I_PT_MARK;
    logic [1:0]  O_BRESP, O_RRESP, resp;
    run_state_t  O_RUN_STATE;
    int          n_fail, checks, cyc, na, ta, tr, hi, pr;
    row_t rows [8] = '{'{`REG_CTRL, `CTRL_RST, `RESP_OKAY},
        '{`REG_MKEN, 32'(`MKEN_RST), `RESP_OKAY}, '{`REG_BITDIV, 32'(`BITDIV_RST), `RESP_OKAY},
        '{`REG_PATLEN, 32'(`PATLEN_RST), `RESP_OKAY}, '{`REG_SYMLEN, 32'(`SYMLEN_RST), `RESP_OKAY},
        '{`REG_STATUS, 32'h0, `RESP_OKAY}, '{8'h18, 32'h0, `RESP_SLVERR},
        '{8'h01, 32'h0, `RESP_SLVERR}};

    pattern_trigger_marker_outputs #(.SC_CYCLES(40)) pattern_trigger_marker_outputs_i (.*);
    trigger_source_model trigger_source_model_i (.i_clk(I_CLK), .i_lvl(lvl), .i_lvl2(lvl2),
        .o_trig(I_PATTERN_TRIGGER_IN), .o_trig2(I_PATTERN_TRIGGER_IN_SECONDARY),
        .o_data(I_EXT_DATA));

    always #25 I_CLK = ~I_CLK;

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        {aw_done, w_done} = 2'b00;
        I_AWADDR <= a;
        I_WDATA <= d;
        {I_AWVALID, I_WVALID, I_BREADY} <= 3'b111;
        while (!(aw_done && w_done)) begin
            @(posedge I_CLK);
            if (I_AWVALID && O_AWREADY === 1'b1) aw_done = 1'b1;
            if (I_WVALID && O_WREADY === 1'b1) w_done = 1'b1;
            I_AWVALID <= !aw_done;
            I_WVALID <= !w_done;
        end
        do @(posedge I_CLK); while (O_BVALID !== 1'b1);
        resp = O_BRESP;
        I_BREADY <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge I_CLK);
        I_ARADDR <= a;
        {I_ARVALID, I_RREADY} <= 2'b11;
        do @(posedge I_CLK); while (O_ARREADY !== 1'b1);
        I_ARVALID <= 1'b0;
        do @(posedge I_CLK); while (O_RVALID !== 1'b1);
        rdat = O_RDATA;
        resp = O_RRESP;
        I_RREADY <= 1'b0;
    endtask

    // Moves one trigger pin, then watches 80 clocks for pulses and state changes
    task automatic fire(input logic sec, input logic l);
        @(posedge I_CLK);
        if (sec) lvl2 <= l;
        else lvl <= l;
        na = 0;
        ta = 0;
        tr = 0;
        for (int i = 0; i < 80; i++) begin
            @(posedge I_CLK);
            na += int'(O_ARB_TRIG === 1'b1);
            if (ta == 0 && O_RUN_STATE === ST_ARM) ta = i;
            if (ta > 0 && tr == 0 && O_RUN_STATE === ST_RUN) tr = i;
        end
    endtask

    // High time and period of an output, in clocks
    task automatic per(ref logic s);
        while (s !== 1'b0) @(posedge I_CLK);
        while (s !== 1'b1) @(posedge I_CLK);
        hi = 0;
        while (s === 1'b1) begin
            @(posedge I_CLK);
            hi++;
        end
        pr = hi;
        while (s !== 1'b1) begin
            @(posedge I_CLK);
            pr++;
        end
    endtask

    // Loads happen a cycle before the point so the new enables apply to it
    task automatic mark(input logic seg, input logic seq, input logic [3:0] m);
        @(posedge I_CLK);
        {I_SEG_LOAD, I_SEQ_LOAD} <= {seg, seq};
        @(posedge I_CLK);
        {I_SEG_LOAD, I_SEQ_LOAD, I_PT_VALID} <= 3'b001;
        I_PT_MARK <= m;
        @(posedge I_CLK);
        I_PT_VALID <= 1'b0;
        repeat (3) @(posedge I_CLK);
    endtask

    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        I_CLK = 1'b0;
        {I_RSTN, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} <= '0;
        {I_PT_VALID, I_SEG_LOAD, I_SEQ_LOAD, I_ALTERNATE_POWER_SYNC_IN, lvl, lvl2} <= '0;
        {I_AWADDR, I_ARADDR, I_WDATA, I_PT_MARK} <= '0;
        I_WSTRB <= 4'hf;
        repeat (8) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        foreach (rows[k]) begin
            rd(rows[k].a);
            chk(rdat, rows[k].d);
            chk(resp, rows[k].r);
        end
        fire(1'b0, 1'b1);
        chk(na, 0);
        chk(O_EVENT2, 1'b1);
        wr(`REG_PATLEN, 32'h4);
        chk(resp, `RESP_OKAY);
        wr(`REG_STATUS, 32'h0);
        chk(resp, `RESP_SLVERR);
        wr(`REG_CTRL, 32'h1);
        fire(1'b0, 1'b0);
        chk(na, 0);
        fire(1'b0, 1'b1);
        chk(na, 1);
        chk(tr >= 13 && tr <= 27, 1);
        chk(O_RUN_STATE, ST_IDLE);
        wr(`REG_CTRL, 32'h5);
        fire(1'b0, 1'b0);
        chk(na, 1);
        fire(1'b1, 1'b1);
        chk(tr > 0, 1);
        wr(`REG_CTRL, 32'h4b);
        fire(1'b0, 1'b1);
        chk(O_EVENT2, 1'b0);
        per(O_BIT_CLK);
        chk(pr, 2 * `BITDIV_RST);
        per(O_SYMBOL_SYNC_OUT);
        chk(hi, 2 * `BITDIV_RST);
        chk(pr, 2 * `BITDIV_RST * `SYMLEN_RST);
        per(O_SER_DATA);
        chk(pr, 4 * `BITDIV_RST);
        wr(`REG_SYMLEN, 32'h8);
        while (O_SYMBOL_SYNC_OUT !== 1'b1) @(posedge I_CLK);
        while (O_SYMBOL_SYNC_OUT === 1'b1) @(posedge I_CLK);
        // Without the realignment the next sync would be seven bits away
        I_ALTERNATE_POWER_SYNC_IN <= 1'b1;
        hi = 0;
        while (O_SYMBOL_SYNC_OUT !== 1'b1) begin
            @(posedge I_CLK);
            hi++;
        end
        chk(hi, 2 * `BITDIV_RST);
        I_ALTERNATE_POWER_SYNC_IN <= 1'b0;
        fire(1'b0, 1'b0);
        fire(1'b0, 1'b1);
        chk(ta > 0 && tr > ta, 1);
        wr(`REG_CTRL, 32'h0b);
        repeat (2) @(posedge I_CLK);
        chk(O_EVENT2, 1'b1);
        wr(`REG_CTRL, 32'h21);
        mark(1'b1, 1'b0, 4'h5);
        chk({O_EVENT4, O_EVENT3, O_EVENT2, O_EVENT1}, 4'h5);
        wr(`REG_CTRL, 32'hf21);
        mark(1'b0, 1'b0, 4'h5);
        chk({O_EVENT4, O_EVENT3, O_EVENT2, O_EVENT1}, 4'ha);
        wr(`REG_CTRL, 32'h21);
        mark(1'b0, 1'b1, 4'hf);
        chk({O_EVENT4, O_EVENT3, O_EVENT2, O_EVENT1}, 4'h0);
        wr(`REG_CTRL, 32'h15);
        fire(1'b0, 1'b0);
        chk(na, 0);
        per(O_EVENT2);
        chk(pr, 40);
        I_RSTN <= 1'b0;
        repeat (2) @(posedge I_CLK);
        chk({O_EVENT2, O_BVALID, O_BIT_CLK, O_RUN_STATE}, {3'b100, ST_IDLE});
        I_RSTN <= 1'b1;
        rd(`REG_CTRL);
        chk(rdat, `CTRL_RST);
        final_report();
    end
endmodule

// *** verif/trigger_source_model.sv ***
/* Far-side model: pattern trigger sources and external serial data.
   Assumes the bench sets the wanted trigger levels just after i_clk edges. */
`timescale 1ns/1ps
module trigger_source_model (
    input  wire logic i_clk,
    input  wire logic i_lvl,
    input  wire logic i_lvl2,
    output logic      o_trig,
    output logic      o_trig2,
    output logic      o_data
);
    logic       lclk;
    logic [1:0] hold_q;
    initial begin
        {lclk, o_trig, o_trig2, o_data, hold_q} = '0;
        #7;
        forever #200 lclk = ~lclk;
    end
    // Data source runs on its own clock, unrelated in phase to i_clk
    always @(posedge lclk) o_data <= ~o_data;
    // Each level stands three clocks, so no pulse is ever short
    always @(posedge i_clk) begin
        if (hold_q != 2'h3) hold_q <= hold_q + 2'h1;
        if (hold_q >= 2'h2 && {i_lvl, i_lvl2} != {o_trig, o_trig2}) begin
            {o_trig, o_trig2} <= {i_lvl, i_lvl2};
            hold_q <= 2'h0;
        end
    end
endmodule

// *** verilog/pattern_trigger_marker_outputs.sv ***
/*
 * Rear-port timing logic of a baseband pattern generator: trigger capture,
 * bit clock, serial data, symbol sync, marker and data-enable outputs,
 * with an AXI4-Lite register slave.
 * Assumes one 20 MHz clock; all pins arrive asynchronously; waveform point
 * flags and segment/sequence load pulses come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "pattern_params.svh"

module pattern_trigger_marker_outputs #(
    parameter int SC_CYCLES = `SC_CYCLES
) (
    input  wire logic                    I_CLK,
    input  wire logic                    I_RSTN,
    input  wire logic [7:0]              I_AWADDR,
    input  wire logic                    I_AWVALID,
    output logic                         O_AWREADY,
    input  wire logic [31:0]             I_WDATA,
    input  wire logic [3:0]              I_WSTRB,
    input  wire logic                    I_WVALID,
    output logic                         O_WREADY,
    output logic [1:0]                   O_BRESP,
    output logic                         O_BVALID,
    input  wire logic                    I_BREADY,
    input  wire logic [7:0]              I_ARADDR,
    input  wire logic                    I_ARVALID,
    output logic                         O_ARREADY,
    output logic [31:0]                  O_RDATA,
    output logic [1:0]                   O_RRESP,
    output logic                         O_RVALID,
    input  wire logic                    I_RREADY,
    input  wire logic                    I_PATTERN_TRIGGER_IN,
    input  wire logic                    I_PATTERN_TRIGGER_IN_SECONDARY,
    input  wire logic                    I_ALTERNATE_POWER_SYNC_IN,
    input  wire logic                    I_EXT_DATA,
    input  wire logic                    I_PT_VALID,
    input  wire logic [3:0]              I_PT_MARK,
    input  wire logic                    I_SEG_LOAD,
    input  wire logic                    I_SEQ_LOAD,
    output logic                         O_EVENT1,
    output logic                         O_EVENT2,
    output logic                         O_EVENT3,
    output logic                         O_EVENT4,
    output logic                         O_BIT_CLK,
    output logic                         O_SER_DATA,
    output logic                         O_SYMBOL_SYNC_OUT,
    output logic                         O_ARB_TRIG,
    output pattern_pkg::run_state_t      O_RUN_STATE
);
    import pattern_pkg::*;

    logic [31:0] ctrl_q;
    logic [3:0]  mken_q;
    logic [7:0]  half_q;
    logic [15:0] patlen_q;
    logic [3:0]  symlen_q;
    logic [7:0]  aw_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic        aw_have_q, w_have_q;
    logic [2:0]  tr_q, sec_q, alt_q;
    logic [1:0]  ext_q;
    logic        lat_q, lat_sec_q, single_q;
    run_state_t  st_q;
    logic [7:0]  div_q;
    logic        bclk_q;
    logic [15:0] bit_q;
    logic [3:0]  sym_q;
    logic [8:0]  lfsr_q;
    logic [31:0] sc_q;
    logic        sc_mark_q;
    logic [3:0]  pt_q;
    logic [3:0]  ev_q;
    logic [7:0]  tcnt_q;
    logic [15:0] age_q;

    // Register fields and decode
    wire        bb      = ctrl_q[`CTL_BB];
    wire        cont    = ctrl_q[`CTL_CONT];
    wire        fall    = ctrl_q[`CTL_FALL];
    wire        ext_src = ctrl_q[`CTL_EXT];
    wire        sc_opt  = ctrl_q[`CTL_SC];
    wire        arbitrary_waveform_generator     = ctrl_q[`CTL_ARB];
    wire        tslot   = ctrl_q[`CTL_TSLOT];
    wire [3:0]  pol     = ctrl_q[`CTL_POL_HI:`CTL_POL_LO];
    wire        do_wr   = aw_have_q && w_have_q && !O_BVALID;
    wire [31:0] wmask   = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
    wire        wr_ctrl = do_wr && (aw_q == `REG_CTRL);
    wire        wr_mken = do_wr && (aw_q == `REG_MKEN);
    wire        wr_div  = do_wr && (aw_q == `REG_BITDIV);
    wire        wr_len  = do_wr && (aw_q == `REG_PATLEN);
    wire        wr_sym  = do_wr && (aw_q == `REG_SYMLEN);
    wire        wr_ok   = wr_ctrl | wr_mken | wr_div | wr_len | wr_sym;
    wire        rd_go   = I_ARVALID && O_ARREADY;
    wire        rd_ok   = (I_ARADDR <= `REG_STATUS) && (I_ARADDR[1:0] == 2'b00);
    wire [31:0] merged  = (I_WDATA & 32'hffff_ffff);
    wire [31:0] stat    = {16'h0000, tcnt_q, 5'h00, lat_q, st_q};
    logic [31:0] rsel;
    always_comb begin
        case (I_ARADDR)
            `REG_CTRL:   rsel = ctrl_q;
            `REG_MKEN:   rsel = {28'h0000000, mken_q};
            `REG_BITDIV: rsel = {24'h000000, half_q};
            `REG_PATLEN: rsel = {16'h0000, patlen_q};
            `REG_SYMLEN: rsel = {28'h0000000, symlen_q};
            `REG_STATUS: rsel = stat;
            default:     rsel = 32'h0000_0000;
        endcase
    end

    // Write address and data are taken independently, then paired
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_q      <= 8'h00;
            wd_q      <= 32'h0000_0000;
            ws_q      <= 4'h0;
            O_AWREADY <= 1'b1;
            O_WREADY  <= 1'b1;
            O_BVALID  <= 1'b0;
            O_BRESP   <= `RESP_OKAY;
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                aw_q      <= I_AWADDR;
                aw_have_q <= 1'b1;
                O_AWREADY <= 1'b0;
            end
            if (I_WVALID && O_WREADY) begin
                wd_q     <= merged;
                ws_q     <= I_WSTRB;
                w_have_q <= 1'b1;
                O_WREADY <= 1'b0;
            end
            if (do_wr) begin
                O_BVALID  <= 1'b1;
                O_BRESP   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
            if (O_BVALID && I_BREADY) begin
                O_BVALID  <= 1'b0;
                O_AWREADY <= 1'b1;
                O_WREADY  <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_ARREADY <= 1'b1;
            O_RVALID  <= 1'b0;
            O_RDATA   <= 32'h0000_0000;
            O_RRESP   <= `RESP_OKAY;
        end else if (rd_go) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b1;
            O_RDATA   <= rsel;
            O_RRESP   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (O_RVALID && I_RREADY) begin
            O_RVALID  <= 1'b0;
            O_ARREADY <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_q   <= `CTRL_RST;
            half_q   <= `BITDIV_RST;
            patlen_q <= `PATLEN_RST;
            symlen_q <= `SYMLEN_RST;
        end else begin
            if (wr_ctrl)
                ctrl_q <= (ctrl_q & ~wmask) | (wd_q & wmask);
            if (wr_div && ws_q[0])
                half_q <= wd_q[7:0];
            if (wr_len)
                patlen_q <= (patlen_q & ~wmask[15:0]) | (wd_q[15:0] & wmask[15:0]);
            if (wr_sym && ws_q[0])
                symlen_q <= wd_q[3:0];
        end
    end

    // Segment load enables all markers and beats a sequence clear
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN)
            mken_q <= `MKEN_RST;
        else if (I_SEG_LOAD)
            mken_q <= 4'hf;
        else if (wr_mken && ws_q[0])
            mken_q <= wd_q[3:0];
        else if (I_SEQ_LOAD)
            mken_q <= 4'h0;
    end

    // Pin synchronisers; stage 0 is read only by stage 1
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tr_q  <= 3'h0;
            sec_q <= 3'h0;
            alt_q <= 3'h0;
            ext_q <= 2'h0;
        end else begin
            tr_q  <= {tr_q[1:0], I_PATTERN_TRIGGER_IN};
            sec_q <= {sec_q[1:0], I_PATTERN_TRIGGER_IN_SECONDARY};
            alt_q <= {alt_q[1:0], I_ALTERNATE_POWER_SYNC_IN};
            ext_q <= {ext_q[0], I_EXT_DATA};
        end
    end

    // A level held 100 ns spans two clocks, so no edge slips the synchroniser
    wire tr_edge  = fall ? (tr_q[2] & ~tr_q[1]) : (~tr_q[2] & tr_q[1]);
    wire even_sec = sc_opt & tr_edge;
    wire p_trig   = bb & ~sc_opt & tr_edge;
    wire s_trig   = bb & ~sec_q[2] & sec_q[1];
    wire trig_set = p_trig | s_trig;
    wire alt_rise = ~alt_q[2] & alt_q[1];

    // Bit clock divider; rise and fall are one-cycle enables
    wire [7:0] half = (half_q == 8'h00) ? 8'h01 : half_q;
    wire       tick = bb && (div_q == half - 8'h01);
    wire       bit_rise = tick & ~bclk_q;
    wire       bit_fall = tick & bclk_q;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            div_q  <= 8'h00;
            bclk_q <= 1'b0;
        end else if (!bb) begin
            div_q  <= 8'h00;
            bclk_q <= 1'b0;
        end else begin
            div_q  <= tick ? 8'h00 : div_q + 8'h01;
            bclk_q <= bclk_q ^ tick;
        end
    end

    // Trigger latch: a new edge in the sampling cycle keeps the latch set
    wire sample = bit_fall && lat_q;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            lat_q     <= 1'b0;
            lat_sec_q <= 1'b0;
        end else if (trig_set) begin
            lat_q     <= 1'b1;
            lat_sec_q <= s_trig & ~p_trig;
        end else if (sample || !bb) begin
            lat_q     <= 1'b0;
            lat_sec_q <= 1'b0;
        end
    end

    // Falling sample, then two rising edges: first bit 1.5 to 2.5 periods out
    wire last_bit = (bit_q == patlen_q - 16'h0001);
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st_q     <= ST_IDLE;
            single_q <= 1'b1;
        end else if (!bb) begin
            st_q <= ST_IDLE;
        end else if (sample) begin
            st_q     <= ST_ARM;
            single_q <= lat_sec_q | ~cont;
        end else if (bit_rise) begin
            case (st_q)
                ST_ARM:  st_q <= ST_WAIT;
                ST_WAIT: st_q <= ST_RUN;
                ST_RUN:  st_q <= (last_bit && single_q) ? ST_IDLE : ST_RUN;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Pattern bit counter and internal PRBS source
    wire start = bit_rise && (st_q == ST_WAIT);
    wire run_b = bit_rise && (st_q == ST_RUN);
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            bit_q  <= 16'h0000;
            lfsr_q <= `LFSR_SEED;
        end else if (start || (run_b && last_bit)) begin
            bit_q  <= 16'h0000;
            lfsr_q <= `LFSR_SEED;
        end else if (run_b) begin
            bit_q  <= bit_q + 16'h0001;
            lfsr_q <= {lfsr_q[0] ^ lfsr_q[`LFSR_TAP], lfsr_q[8:1]};
        end
    end

    // Alternate power edge realigns symbol framing to the external data
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN)
            sym_q <= 4'h0;
        // Bit 0 leaves at the start edge, so counting resumes at one there;
        // restarting at zero would stretch the first sync pulse to two bits
        else if (start)
            sym_q <= (symlen_q > 4'h1) ? 4'h1 : 4'h0;
        else if (alt_rise)
            sym_q <= 4'h0;
        else if (run_b)
            sym_q <= (sym_q >= symlen_q - 4'h1) ? 4'h0 : sym_q + 4'h1;
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_SER_DATA        <= 1'b0;
            O_SYMBOL_SYNC_OUT <= 1'b0;
        end else if (!bb) begin
            O_SER_DATA        <= 1'b0;
            O_SYMBOL_SYNC_OUT <= 1'b0;
        end else if (bit_rise) begin
            O_SER_DATA        <= ext_src ? ext_q[1] : lfsr_q[0];
            O_SYMBOL_SYNC_OUT <= (st_q == ST_WAIT) || (run_b && sym_q == 4'h0);
        end else if (st_q == ST_IDLE) begin
            O_SYMBOL_SYNC_OUT <= 1'b0;
        end
    end

    // Short-code counter restarts on each even-second edge
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sc_q      <= 32'h0000_0000;
            sc_mark_q <= 1'b0;
        end else if (!(bb && sc_opt) || even_sec) begin
            sc_q      <= 32'h0000_0000;
            sc_mark_q <= bb && even_sec;
        end else begin
            sc_q      <= (sc_q == SC_CYCLES - 1) ? 32'h0000_0000 : sc_q + 32'h0000_0001;
            sc_mark_q <= (sc_q == SC_CYCLES - 1);
        end
    end

    // Point flags are gated by the per-channel marker enable
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN)
            pt_q <= 4'h0;
        else if (I_PT_VALID)
            pt_q <= I_PT_MARK & mken_q;
    end

    // Event pins; marker 3 and 4 only count in waveform mode
    wire       den_n = ~(ext_src && tslot && st_q == ST_RUN);
    wire [3:0] gate  = {arbitrary_waveform_generator, arbitrary_waveform_generator, 1'b1, 1'b1} & {4{bb}};
    wire [3:0] mk_lv;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mark
            assign mk_lv[gi] = pol[gi] ^ (pt_q[gi] & gate[gi]);
        end
    endgenerate
    wire ev2 = !bb ? 1'b1 : sc_opt ? sc_mark_q : arbitrary_waveform_generator ? mk_lv[1] : den_n;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ev_q       <= 4'h2;
            O_BIT_CLK  <= 1'b0;
            O_ARB_TRIG <= 1'b0;
            tcnt_q     <= 8'h00;
        end else begin
            ev_q       <= {mk_lv[3], mk_lv[2], ev2, mk_lv[0]};
            O_BIT_CLK  <= bclk_q;
            O_ARB_TRIG <= trig_set;
            tcnt_q     <= tcnt_q + {7'h00, trig_set};
        end
    end
    assign O_EVENT1    = ev_q[0];
    assign O_EVENT2    = ev_q[1];
    assign O_EVENT3    = ev_q[2];
    assign O_EVENT4    = ev_q[3];
    assign O_RUN_STATE = st_q;

    // Helper: cycles since the last accepted trigger edge
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN)
            age_q <= 16'h0000;
        else if (trig_set)
            age_q <= 16'h0000;
        else if (age_q != 16'hffff)
            age_q <= age_q + 16'h0001;
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    a_den_low_run: assert property (
        bb && !sc_opt && !arbitrary_waveform_generator && ext_src && tslot && st_q == ST_RUN |=> !O_EVENT2)
        else $error("data enable not low while accepting data");
    a_den_high_int: assert property (
        bb && !sc_opt && !arbitrary_waveform_generator && !ext_src |=> O_EVENT2)
        else $error("data enable asserted without external data");
    a_sc_marker: assert property (
        bb && sc_opt && sc_q == SC_CYCLES - 1 && !even_sec |=> ##1 O_EVENT2)
        else $error("short code marker missing");
    a_sc_reset_idle: assert property (
        bb && sc_opt && !sc_mark_q |=> !O_EVENT2)
        else $error("system reset output active between short codes");
    a_mark_pos: assert property (
        I_PT_VALID && I_PT_MARK[0] && mken_q[0] && bb && !pol[0] && !I_SEQ_LOAD
        ##1 bb && !pol[0] |=> O_EVENT1)
        else $error("marker one not asserted");
    a_seg_enable: assert property (
        I_SEG_LOAD |=> mken_q == 4'hf)
        else $error("segment load did not enable markers");
    a_seq_disable: assert property (
        I_SEQ_LOAD && !I_SEG_LOAD && !wr_mken |=> mken_q == 4'h0)
        else $error("sequence load did not disable markers");
    a_trig_latch: assert property (
        trig_set |=> lat_q)
        else $error("trigger edge not latched");
    a_latch_clear: assert property (
        sample && !trig_set |=> !lat_q ##0 st_q == ST_ARM)
        else $error("sampled trigger not cleared");
    a_first_bit: assert property (
        $rose(st_q == ST_RUN) |-> age_q >= {8'h00, half} * 16'h0003)
        else $error("first bit earlier than 1.5 bit periods");
    a_sym_edge: assert property (
        $changed(O_SYMBOL_SYNC_OUT) && bb && st_q == ST_RUN |-> $past(bit_rise))
        else $error("symbol sync moved off a data clock edge");
    a_no_bb_quiet: assert property (
        !bb |=> !O_SER_DATA && !O_SYMBOL_SYNC_OUT && !O_ARB_TRIG && O_EVENT2)
        else $error("aux outputs active without baseband generator");

    c_single_run: cover property (st_q == ST_WAIT ##1 st_q == ST_RUN);
    c_restart: cover property (st_q == ST_RUN && sample);
    c_sec_start: cover property (s_trig ##[1:100] st_q == ST_ARM);
    c_sc_mark: cover property (sc_mark_q && !even_sec);
endmodule
